// ### verilog/pcir_top.sv
`default_nettype none

module pcir_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [7:0]  portb_pins,
  input  wire logic [7:0]  portc_pins,
  input  wire logic [7:0]  porte_pins,
  input  wire logic        portg_pin5,
  input  wire logic        sleep_active,
  output var  logic        change_summary_flag,
  output var  logic        change_irq,
  output var  logic        wake_req
);

  typedef struct packed {
    pcir_pkg::pcir_bus_st_t bus;
    logic                   awready;
    logic                   wready;
    logic                   arready;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   rvalid;
    logic [1:0]             rresp;
    logic [31:0]            rdata;
    logic [24:0]            ren;
    logic [24:0]            fen;
    logic [24:0]            flags;
    logic [2:0]             ctrl;
    logic                   summary;
    logic                   irq;
    logic                   wake;
  } pcir_st_t;

  pcir_st_t    st_ff;
  pcir_st_t    nxt_st;
  logic [24:0] rise;
  logic [24:0] fall;
  logic [24:0] rise_hit;
  logic [24:0] fall_hit;
  logic [24:0] hit;
  logic [24:0] lock_mask;
  logic [24:0] sw_flags;
  logic        wr_fire;
  logic        rd_fire;
  logic [3:0]  widx;
  logic [3:0]  ridx;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] get_port(input logic [24:0] vec, input logic [1:0] port);
    logic [7:0] b;
    b = 8'h00;
    case (port)
      2'd0:    b = vec[7:0];
      2'd1:    b = vec[15:8];
      2'd2:    b = vec[23:16];
      default: b = {2'b00, vec[24], 5'b00000};
    endcase
    return b;
  endfunction

  function automatic logic [24:0] put_port(input logic [24:0] vec, input logic [1:0] port,
                                           input logic [7:0] b);
    logic [24:0] v;
    v = vec;
    case (port)
      2'd0:    v[7:0]   = b;
      2'd1:    v[15:8]  = b;
      2'd2:    v[23:16] = b;
      default: v[24]    = b[pcir_pkg::PORTG_BIT];
    endcase
    return v;
  endfunction

  function automatic logic reg_ok(input logic [7:0] addr);
    return (addr[1:0] == 2'b00) && (addr[7:2] <= {2'b00, pcir_pkg::IDX_LAST});
  endfunction

  // ------------------------------------------------------------
  // edge detection
  // ------------------------------------------------------------
  pcir_edge_det u_edge (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pins    ({portg_pin5, porte_pins, portc_pins, portb_pins}),
    .rise    (rise),
    .fall    (fall)
  );

  always_comb begin
    lock_mask = {(st_ff.ctrl[pcir_pkg::CTRL_EXTRST_BIT] | st_ff.ctrl[pcir_pkg::CTRL_LVP_BIT]),
                 24'h000000};
    rise_hit  = rise & st_ff.ren & ~lock_mask;
    fall_hit  = fall & st_ff.fen & ~lock_mask;
    hit       = rise_hit | fall_hit;
  end

  // ------------------------------------------------------------
  // register file and bus slave
  // ------------------------------------------------------------
  always_comb begin
    wr_fire  = (st_ff.bus == pcir_pkg::ST_IDLE) && st_ff.awready;
    rd_fire  = (st_ff.bus == pcir_pkg::ST_IDLE) && st_ff.arready;
    widx     = s_axi_awaddr[5:2];
    ridx     = s_axi_araddr[5:2];
    sw_flags = st_ff.flags;
    nxt_st   = st_ff;
    nxt_st.awready = 1'b0;
    nxt_st.wready  = 1'b0;
    nxt_st.arready = 1'b0;

    case (st_ff.bus)
      pcir_pkg::ST_IDLE: begin
        if (wr_fire) begin
          nxt_st.bus    = pcir_pkg::ST_WRESP;
          nxt_st.bvalid = 1'b1;
          nxt_st.bresp  = reg_ok(s_axi_awaddr) ? pcir_pkg::RESP_OKAY : pcir_pkg::RESP_SLVERR;
          if (reg_ok(s_axi_awaddr) && s_axi_wstrb[0]) begin
            if (widx == pcir_pkg::IDX_CTRL) begin
              nxt_st.ctrl = s_axi_wdata[2:0];
            end else if (widx < pcir_pkg::IDX_CTRL) begin
              case (widx % 4'd3)
                4'd0:    nxt_st.ren = put_port(st_ff.ren, 2'(widx / 4'd3), s_axi_wdata[7:0]);
                4'd1:    nxt_st.fen = put_port(st_ff.fen, 2'(widx / 4'd3), s_axi_wdata[7:0]);
                default: sw_flags   = put_port(st_ff.flags, 2'(widx / 4'd3), s_axi_wdata[7:0]);
              endcase
            end
          end
        end else if (rd_fire) begin
          nxt_st.bus    = pcir_pkg::ST_RRESP;
          nxt_st.rvalid = 1'b1;
          nxt_st.rresp  = reg_ok(s_axi_araddr) ? pcir_pkg::RESP_OKAY : pcir_pkg::RESP_SLVERR;
          nxt_st.rdata  = 32'h00000000;
          if (!reg_ok(s_axi_araddr)) begin
            nxt_st.rdata = 32'h00000000;
          end else if (ridx == pcir_pkg::IDX_STATUS) begin
            nxt_st.rdata[pcir_pkg::STAT_SUMMARY_BIT] = st_ff.summary;
            nxt_st.rdata[pcir_pkg::STAT_IRQ_BIT]     = st_ff.irq;
          end else if (ridx == pcir_pkg::IDX_CTRL) begin
            nxt_st.rdata[2:0] = st_ff.ctrl;
          end else begin
            case (ridx % 4'd3)
              4'd0:    nxt_st.rdata[7:0] = get_port(st_ff.ren, 2'(ridx / 4'd3));
              4'd1:    nxt_st.rdata[7:0] = get_port(st_ff.fen, 2'(ridx / 4'd3));
              default: nxt_st.rdata[7:0] = get_port(st_ff.flags, 2'(ridx / 4'd3));
            endcase
          end
        end else if (s_axi_awvalid && s_axi_wvalid) begin
          nxt_st.awready = 1'b1;
          nxt_st.wready  = 1'b1;
        end else if (s_axi_arvalid) begin
          nxt_st.arready = 1'b1;
        end
      end
      pcir_pkg::ST_WRESP: begin
        if (s_axi_bready) begin
          nxt_st.bvalid = 1'b0;
          nxt_st.bus    = pcir_pkg::ST_IDLE;
        end
      end
      pcir_pkg::ST_RRESP: begin
        if (s_axi_rready) begin
          nxt_st.rvalid = 1'b0;
          nxt_st.bus    = pcir_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_st.bus = pcir_pkg::ST_IDLE;
      end
    endcase

    // hardware set wins over a software clear
    nxt_st.flags   = sw_flags | hit;
    nxt_st.summary = |nxt_st.flags;
    nxt_st.irq     = nxt_st.summary & st_ff.ctrl[pcir_pkg::CTRL_MASTER_EN_BIT];
    nxt_st.wake    = nxt_st.irq & sleep_active;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff       <= '0;
      st_ff.bus   <= pcir_pkg::ST_IDLE;
      st_ff.ren   <= pcir_pkg::RST_VEC;
      st_ff.fen   <= pcir_pkg::RST_VEC;
      st_ff.flags <= pcir_pkg::RST_VEC;
      st_ff.ctrl  <= pcir_pkg::RST_CTRL;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  always_comb begin
    s_axi_awready       = st_ff.awready;
    s_axi_wready        = st_ff.wready;
    s_axi_arready       = st_ff.arready;
    s_axi_bvalid        = st_ff.bvalid;
    s_axi_bresp         = st_ff.bresp;
    s_axi_rvalid        = st_ff.rvalid;
    s_axi_rresp         = st_ff.rresp;
    s_axi_rdata         = st_ff.rdata;
    change_summary_flag = st_ff.summary;
    change_irq          = st_ff.irq;
    wake_req            = st_ff.wake;
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_rise_sets_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    (rise_hit != 25'h0) |=> ((st_ff.flags & $past(rise_hit)) == $past(rise_hit)))
    else $error("enabled rising edge did not set its flag");

  a_fall_sets_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    (fall_hit != 25'h0) |=> ((st_ff.flags & $past(fall_hit)) == $past(fall_hit)))
    else $error("enabled falling edge did not set its flag");

  a_no_stray_set: assert property (@(posedge aclk) disable iff (!aresetn)
    (!wr_fire && (hit == 25'h0)) |=> (st_ff.flags == $past(st_ff.flags)))
    else $error("flag changed with no edge and no write");

  a_disabled_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
    ((hit & ~(st_ff.ren | st_ff.fen)) == 25'h0))
    else $error("edge recorded on a pin with both enables off");

  a_locked_g_pin: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_ff.ctrl[1] || st_ff.ctrl[2]) |-> !hit[24])
    else $error("port g pin 5 detected while locked out");

  a_summary_or: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 (change_summary_flag == (|st_ff.flags)))
    else $error("summary flag differs from or of flags");

  a_irq_gated: assert property (@(posedge aclk) disable iff (!aresetn)
    (!st_ff.ctrl[0] && !nxt_st.ctrl[0]) |=> !change_irq)
    else $error("interrupt raised with master enable off");

  a_set_wins: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_fire && (hit != 25'h0)) |=> ((st_ff.flags & $past(hit)) == $past(hit)))
    else $error("edge lost during flag write");

  a_wake_on_edge: assert property (@(posedge aclk) disable iff (!aresetn)
    (hit != 25'h0 && st_ff.ctrl[0] && sleep_active) |=> (wake_req && change_summary_flag))
    else $error("no wake after enabled edge in sleep");

  a_rdata_upper: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> (s_axi_rdata[31:8] == 24'h000000))
    else $error("unimplemented read bits not zero");

  a_reset_clear: assert property (@(posedge aclk)
    !aresetn |=> ((st_ff.ren | st_ff.fen | st_ff.flags) == 25'h0))
    else $error("enables or flags not zero after reset");

  a_bvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_bvalid && !s_axi_bready) |=> $stable(s_axi_bvalid) && $stable(s_axi_bresp))
    else $error("write response dropped before bready");

  a_off_pin_kept: assert property (@(posedge aclk) disable iff (!aresetn)
    !wr_fire |=> (((st_ff.flags ^ $past(st_ff.flags))
                   & ~$past(st_ff.ren | st_ff.fen)) == 25'h0))
    else $error("flag of a disabled pin changed");

  a_flag_clear_write: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_fire && reg_ok(s_axi_awaddr) && s_axi_wstrb[0] && (s_axi_wdata[7:0] == 8'h00)
     && (widx == pcir_pkg::OFS_PORTB_FLAGS[5:2]) && (hit[7:0] == 8'h00))
    |=> (st_ff.flags[7:0] == 8'h00))
    else $error("writing 0 did not clear port b flags");

  a_flags_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    !wr_fire |=> ((st_ff.flags & $past(st_ff.flags)) == $past(st_ff.flags)))
    else $error("flag cleared without a write");

  a_summary_set: assert property (@(posedge aclk) disable iff (!aresetn)
    (hit != 25'h0) |=> change_summary_flag)
    else $error("detected edge did not set summary");

  a_irq_needs_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    change_irq |-> change_summary_flag)
    else $error("interrupt with no flag set");

  a_wake_needs_irq: assert property (@(posedge aclk) disable iff (!aresetn)
    wake_req |-> change_irq)
    else $error("wake request without interrupt");

  a_g_lock_kept: assert property (@(posedge aclk) disable iff (!aresetn)
    ((st_ff.ctrl[pcir_pkg::CTRL_EXTRST_BIT] || st_ff.ctrl[pcir_pkg::CTRL_LVP_BIT]) && !wr_fire)
    |=> $stable(st_ff.flags[24]))
    else $error("port g pin 5 flag moved while locked");

  // ------------------------------------------------------------
  // bus checks
  // ------------------------------------------------------------
  a_rvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_rvalid && !s_axi_rready) |=> (s_axi_rvalid && $stable(s_axi_rdata)
                                          && $stable(s_axi_rresp)))
    else $error("read response changed before rready");

  a_awready_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_awready |=> !s_axi_awready)
    else $error("awready high two cycles");

  a_arready_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arready |=> !s_axi_arready)
    else $error("arready high two cycles");

  a_one_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    !(s_axi_bvalid && s_axi_rvalid))
    else $error("write and read responses together");

  a_slverr_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_rvalid && (s_axi_rresp != pcir_pkg::RESP_OKAY)) |-> (s_axi_rdata == 32'h00000000))
    else $error("refused read returned data");

  a_g_bits_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_fire && (ridx >= pcir_pkg::OFS_PORTG_RISE[5:2]) && (ridx < pcir_pkg::IDX_CTRL))
    |=> ((s_axi_rdata[7:0] & ~pcir_pkg::PORTG_MASK) == 8'h00))
    else $error("unimplemented port g bits read nonzero");

  a_ctrl_upper: assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_fire && (ridx == pcir_pkg::IDX_CTRL)) |=> (s_axi_rdata[31:3] == 29'h0))
    else $error("unimplemented control bits read nonzero");

endmodule

`default_nettype wire

// ### verilog/pcir_pkg.sv
// Contract
// - ports b, c and e each have eight rise enables, eight fall enables and eight flags, bits 7-0.
// - a pin with its rise enable at 1 records positive-going transitions as change events.
// - a pin with its fall enable at 1 records negative-going transitions as change events.
// - a pin with both enables at 0 never records a change event.
// - a flag goes to 1 on a rising edge with rise enable set or a falling edge with fall enable set.
// - any flag set by a detected edge also sets the shared change summary flag.
// - a flag stays 0 while no enabled edge is seen, and software writing 0 to it clears it. Here a software write of 1 also sets a flag.
// - all edge enable registers are read/write and reset to 0 on every reset.
// - flag bits are read/write, set by hardware too, and reset to 0 on every reset.
// - for port g only bit 5 exists in the three registers; bits 7-6 and 4-0 read as 0.
// - every unimplemented register bit reads as 0.
// - with external reset pin enable or low-voltage program enable at 1, port g pin 5 detects nothing.
// - with the master enable cleared, detection and flags go on but no interrupt is raised.
// - the summary flag is the or of all per-pin flags of every port.
// - an enabled edge during a clearing write leaves that flag set whatever was written.
// - with the master enable set, a detected edge wakes the device from sleep, flags already updated.
`default_nettype none

package pcir_pkg;

  localparam int          NPINS        = 25;
  localparam int          ADDR_W       = 8;
  localparam logic [3:0]  IDX_LAST     = 4'hd;
  localparam logic [3:0]  IDX_STATUS   = 4'hd;
  localparam logic [3:0]  IDX_CTRL     = 4'hc;

  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0]  OFS_PORTB_RISE  = 8'h00;
  localparam logic [7:0]  OFS_PORTB_FALL  = 8'h04;
  localparam logic [7:0]  OFS_PORTB_FLAGS = 8'h08;
  localparam logic [7:0]  OFS_PORTC_RISE  = 8'h0c;
  localparam logic [7:0]  OFS_PORTC_FALL  = 8'h10;
  localparam logic [7:0]  OFS_PORTC_FLAGS = 8'h14;
  localparam logic [7:0]  OFS_PORTE_RISE  = 8'h18;
  localparam logic [7:0]  OFS_PORTE_FALL  = 8'h1c;
  localparam logic [7:0]  OFS_PORTE_FLAGS = 8'h20;
  localparam logic [7:0]  OFS_PORTG_RISE  = 8'h24;
  localparam logic [7:0]  OFS_PORTG_FALL  = 8'h28;
  localparam logic [7:0]  OFS_PORTG_FLAGS = 8'h2c;
  localparam logic [7:0]  OFS_CTRL        = 8'h30;
  localparam logic [7:0]  OFS_STATUS      = 8'h34;

  // ------------------------------------------------------------
  // fields and reset values
  // ------------------------------------------------------------
  localparam int          CTRL_MASTER_EN_BIT = 0;
  localparam int          CTRL_EXTRST_BIT    = 1;
  localparam int          CTRL_LVP_BIT       = 2;
  localparam int          STAT_SUMMARY_BIT   = 0;
  localparam int          STAT_IRQ_BIT       = 1;
  localparam int          PORTG_BIT          = 5;
  localparam logic [7:0]  PORTG_MASK         = 8'h20;
  localparam logic [24:0] RST_VEC            = 25'h0;
  localparam logic [2:0]  RST_CTRL           = 3'h0;
  localparam logic [1:0]  RESP_OKAY          = 2'h0;
  localparam logic [1:0]  RESP_SLVERR        = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WRESP = 2'b01,
    ST_RRESP = 2'b10
  } pcir_bus_st_t;

endpackage

`default_nettype wire

// ### verilog/pcir_edge_det.sv
`default_nettype none

module pcir_edge_det (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [24:0] pins,
  output var  logic [24:0] rise,
  output var  logic [24:0] fall
);

  typedef struct packed {
    logic [24:0] meta;
    logic [24:0] sync;
    logic [24:0] prev;
  } pcir_edge_st_t;

  pcir_edge_st_t st_ff;
  pcir_edge_st_t nxt_st;

  // ------------------------------------------------------------
  // two-stage synchroniser, then previous sample
  // ------------------------------------------------------------
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.meta = pins;
    nxt_st.sync = st_ff.meta;
    nxt_st.prev = st_ff.sync;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // current sample against previous sample
  always_comb begin
    rise = st_ff.sync & ~st_ff.prev;
    fall = ~st_ff.sync & st_ff.prev;
  end

endmodule

`default_nettype wire

// ### bench/pcir_pin_model.sv
`default_nettype none

module pcir_pin_model (
  input  wire logic       aclk,
  output var  logic [7:0] portb_pins,
  output var  logic [7:0] portc_pins,
  output var  logic [7:0] porte_pins,
  output var  logic       portg_pin5
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    portb_pins = 8'h00;
    portc_pins = 8'h00;
    porte_pins = 8'h00;
    portg_pin5 = 1'b0;
  end

  // levels change after an edge and hold for whole cycles
  task automatic drive(input logic [7:0] b, input logic [7:0] c, input logic [7:0] e,
                       input logic g);
    @(posedge aclk);
    portb_pins <= b;
    portc_pins <= c;
    porte_pins <= e;
    portg_pin5 <= g;
  endtask
endmodule

`default_nettype wire

// ### bench/testbench.sv
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        aclk;
  logic        aresetn;
  logic [7:0]  s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [7:0]  s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic [7:0]  portb_pins;
  logic [7:0]  portc_pins;
  logic [7:0]  porte_pins;
  logic        portg_pin5;
  logic        sleep_active;
  logic        change_summary_flag;
  logic        change_irq;
  logic        wake_req;
  logic [7:0]  ren [4];
  logic [7:0]  fen [4];
  logic [7:0]  flg [4];
  logic [7:0]  pin [4];
  logic [2:0]  ctrl;
  logic [33:0] rq [$];
  logic [1:0]  bq [$];
  integer      seed;
  int          n_errors;
  int          checks;
  logic [31:0] v;

  pcir_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .portb_pins, .portc_pins, .porte_pins,
    .portg_pin5, .sleep_active, .change_summary_flag, .change_irq, .wake_req);

  pcir_pin_model pins_u (.aclk, .portb_pins, .portc_pins, .porte_pins, .portg_pin5);

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // ------------------------------------------------------------
  // checking and bus tasks
  // ------------------------------------------------------------
  task automatic print_verdict;
    if (n_errors == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [33:0] ok(input logic [7:0] d);
    return {pcir_pkg::RESP_OKAY, 24'h0, d};
  endfunction

  function automatic logic [7:0] ofs(input int p, input int r);
    return pcir_pkg::OFS_PORTB_RISE + 8'(12 * p + 4 * r);
  endfunction

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    bq.push_back(r);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 200);
    s_axi_bready <= 1'b0;
    if (s_axi_bvalid !== 1'b1) begin
      n_errors++;
      print_verdict();
    end
    @(posedge aclk);
  endtask

  task automatic axi_read(input logic [7:0] a, input logic [33:0] exp);
    int n;
    rq.push_back(exp);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 200);
    s_axi_rready <= 1'b0;
    if (s_axi_rvalid !== 1'b1) begin
      n_errors++;
      print_verdict();
    end
    @(posedge aclk);
  endtask

  always @(posedge aclk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
      check({s_axi_rresp, s_axi_rdata}, rq.pop_front());
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
      check(34'(s_axi_bresp), 34'(bq.pop_front()));
  end

  task automatic set_ctrl(input logic [2:0] c);
    axi_write(pcir_pkg::OFS_CTRL, 32'(c), pcir_pkg::RESP_OKAY);
    ctrl = c;
  endtask

  // one pin change, then outputs, status and all flag registers
  task automatic step(input logic [3:0][7:0] nw);
    logic [7:0] hit;
    logic       sum;
    logic       irq;
    nw[3] = nw[3] & pcir_pkg::PORTG_MASK;
    for (int p = 0; p < 4; p++) begin
      hit = (~pin[p] & nw[p] & ren[p]) | (pin[p] & ~nw[p] & fen[p]);
      if (p == 3) hit = hit & pcir_pkg::PORTG_MASK & {8{ctrl[2:1] == 2'b00}};
      flg[p] = flg[p] | hit;
      pin[p] = nw[p];
    end
    pins_u.drive(nw[0], nw[1], nw[2], nw[3][5]);
    repeat (5) @(posedge aclk);
    sum = |{flg[0], flg[1], flg[2], flg[3]};
    irq = sum & ctrl[0];
    check(34'(change_summary_flag), 34'(sum));
    check(34'(change_irq), 34'(irq));
    check(34'(wake_req), 34'(irq & sleep_active));
    axi_read(pcir_pkg::OFS_STATUS, ok({6'h0, irq, sum}));
    for (int p = 0; p < 4; p++) axi_read(ofs(p, 2), ok(flg[p]));
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    seed = 32'hb6fd;
    n_errors = 0;
    checks = 0;
    aresetn = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    sleep_active = 1'b0;
    ctrl = 3'h0;
    for (int p = 0; p < 4; p++) begin
      flg[p] = 8'h00;
      pin[p] = 8'h00;
    end
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 14; i++) axi_read(8'(4 * i), ok(8'h00));
    axi_read(8'h38, {pcir_pkg::RESP_SLVERR, 32'h0});
    axi_read(8'h05, {pcir_pkg::RESP_SLVERR, 32'h0});
    axi_write(8'h3c, 32'h1, pcir_pkg::RESP_SLVERR);
    for (int p = 0; p < 4; p++) begin
      v = $random(seed);
      axi_write(ofs(p, 0), v, pcir_pkg::RESP_OKAY);
      ren[p] = v[7:0] & (p == 3 ? pcir_pkg::PORTG_MASK : 8'hff);
      axi_read(ofs(p, 0), ok(ren[p]));
      v = $random(seed);
      axi_write(ofs(p, 1), v, pcir_pkg::RESP_OKAY);
      fen[p] = v[7:0] & (p == 3 ? pcir_pkg::PORTG_MASK : 8'hff);
      axi_read(ofs(p, 1), ok(fen[p]));
    end
    s_axi_wstrb <= 4'h0;
    axi_write(ofs(0, 0), 32'(~ren[0]), pcir_pkg::RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    axi_read(ofs(0, 0), ok(ren[0]));
    axi_write(pcir_pkg::OFS_STATUS, 32'h3, pcir_pkg::RESP_OKAY);
    axi_read(pcir_pkg::OFS_STATUS, ok(8'h00));
    set_ctrl(3'h1);
    axi_read(pcir_pkg::OFS_CTRL, ok(8'h01));
    for (int k = 0; k < 16; k++) begin
      sleep_active <= k[0];
      if (k == 8) set_ctrl(3'h0);
      step({$random(seed)});
    end
    set_ctrl(3'h1);
    for (int p = 0; p < 4; p++) begin
      axi_write(ofs(p, 2), 32'h0, pcir_pkg::RESP_OKAY);
      flg[p] = 8'h00;
    end
    step({pin[3], pin[2], pin[1], pin[0]});
    axi_write(ofs(0, 0), 32'hff, pcir_pkg::RESP_OKAY);
    axi_write(ofs(0, 1), 32'hff, pcir_pkg::RESP_OKAY);
    ren[0] = 8'hff;
    fen[0] = 8'hff;
    step({pin[3], pin[2], pin[1], ~pin[0]});
    pin[0] = ~pin[0];
    pins_u.drive(pin[0], pin[1], pin[2], pin[3][5]);
    @(posedge aclk);
    axi_write(ofs(0, 2), 32'h0, pcir_pkg::RESP_OKAY);
    step({pin[3], pin[2], pin[1], pin[0]});
    axi_write(ofs(3, 0), 32'h20, pcir_pkg::RESP_OKAY);
    axi_write(ofs(3, 1), 32'h20, pcir_pkg::RESP_OKAY);
    ren[3] = 8'h20;
    fen[3] = 8'h20;
    axi_write(ofs(3, 2), 32'h0, pcir_pkg::RESP_OKAY);
    flg[3] = 8'h00;
    sleep_active <= 1'b1;
    set_ctrl(3'h3);
    step({pin[3] ^ 8'h20, pin[2], pin[1], pin[0]});
    set_ctrl(3'h5);
    step({pin[3] ^ 8'h20, pin[2], pin[1], pin[0]});
    set_ctrl(3'h1);
    step({pin[3] ^ 8'h20, pin[2], pin[1], pin[0]});
    // second reset with flags and enables set
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 14; i++) axi_read(8'(4 * i), ok(8'h00));
    print_verdict();
  end
endmodule

`default_nettype wire
